// ### clkdd_pkg.sv
package clkdd_pkg;

  localparam int NUM_CH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LAT_W  = 12;

  // Byte addresses on the register bus
  localparam logic [ADDR_W-1:0] OFF_CH_BASE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CH_LAST   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL    = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_LAT_BASE  = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_LAT_LAST  = 8'h5C;
  localparam int                IDX_LO        = 2;
  localparam int                IDX_HI        = 4;

  // Channel register fields
  localparam int BIT_SOFT_RESET = 31;
  localparam int BIT_PATH_HI    = 18;
  localparam int BIT_PATH_LO    = 17;
  localparam int BIT_CH_EN      = 16;
  localparam int BIT_DIV_HI     = 15;
  localparam int BIT_DIV_LO     = 8;
  localparam int BIT_DLY_HI     = 7;
  localparam int BIT_DLY_LO     = 4;

  // Global register fields
  localparam int BIT_INPUT_SEL  = 28;
  localparam int BIT_GLOBAL_EN  = 27;
  localparam int BIT_POWER_DOWN = 26;

  // Status register fields
  localparam int BIT_ST_SYNC    = 16;
  localparam int BIT_ST_ALLOW   = 17;
  localparam int BIT_ST_PD      = 18;
  localparam int BIT_ST_ARM_LO  = 8;

  typedef enum logic [1:0] {
    PATH_BYPASS  = 2'h0,
    PATH_DIVIDED = 2'h1,
    PATH_DELAYED = 2'h2,
    PATH_DIV_DLY = 2'h3
  } clkdd_path_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ACK  = 2'h2
  } clkdd_bus_st_t;

  // Power-on values
  localparam clkdd_path_t PATH_RST  = PATH_BYPASS;
  localparam logic        CH_EN_RST = 1'b0;
  localparam logic [7:0]  DIV_RST   = 8'h01;
  localparam logic [3:0]  DLY_RST   = 4'h0;
  localparam logic        INSEL_RST = 1'b0;
  localparam logic        GEN_RST   = 1'b1;
  localparam logic        PD_RST    = 1'b0;

  // Added path latency in picoseconds
  localparam int LAT_DIV_PS    = 100;
  localparam int LAT_DLY_PS    = 400;
  localparam int LAT_DIVDLY_PS = 500;
  localparam int DLY_STEP_PS   = 150;

endpackage

// ### clkdd_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
interface clkdd_chan_if;
  import clkdd_pkg::*;
  clkdd_path_t      path_select;
  logic [7:0]       divide_code;
  logic [3:0]       delay_code;
  logic             channel_enable;
  logic             run;
  logic             out_allow;
  logic             sync_hold;
  logic             in_level;
  logic             in_rise;
  logic             out_level;
  logic             armed;
  logic [LAT_W-1:0] added_delay_ps;

  modport ctrl (output path_select, divide_code, delay_code, channel_enable, run, out_allow,
                sync_hold, in_level, in_rise, input out_level, armed, added_delay_ps);
  modport chan (input path_select, divide_code, delay_code, channel_enable, run, out_allow,
                sync_hold, in_level, in_rise, output out_level, armed, added_delay_ps);
endinterface
`default_nettype wire

// ### clkdd_latency.sv
`timescale 1ns/100ps
`default_nettype none
module clkdd_latency
  import clkdd_pkg::*;
(
  input  wire clkdd_path_t      path_select,
  input  wire logic [3:0]       delay_code,
  output logic      [LAT_W-1:0] added_delay_ps
);

  wire [LAT_W-1:0] step_ps = LAT_W'(int'(delay_code) * DLY_STEP_PS);

  always_comb begin
    unique case (path_select)
      PATH_BYPASS:  added_delay_ps = '0;
      PATH_DIVIDED: added_delay_ps = LAT_W'(LAT_DIV_PS);
      PATH_DELAYED: added_delay_ps = LAT_W'(LAT_DLY_PS) + step_ps;
      PATH_DIV_DLY: added_delay_ps = LAT_W'(LAT_DIVDLY_PS) + step_ps;
    endcase
  end

endmodule
`default_nettype wire

// ### clkdd_channel.sv
`timescale 1ns/100ps
`default_nettype none
module clkdd_channel
  import clkdd_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  clkdd_chan_if.chan ch
);

  logic [7:0] cnt_ff;
  logic       div_ff;
  logic       armed_ff;
  logic       out_ff;

  wire div_mode  = ch.path_select[0];
  wire hold      = !ch.run || ch.sync_hold || !ch.channel_enable;
  wire code_ok   = (ch.divide_code != 8'h00);
  wire last_half = (cnt_ff == ch.divide_code - 8'h01);

  // Half period equals divide_code input edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
      div_ff <= 1'b0;
    end else if (hold) begin
      cnt_ff <= 8'h00;
      div_ff <= 1'b0;
    end else if (ch.in_rise && div_mode && code_ok) begin
      cnt_ff <= last_half ? 8'h00 : cnt_ff + 8'h01;
      div_ff <= last_half ? !div_ff : div_ff;
    end
  end

  // Armed by a sync pulse while enabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_ff <= 1'b0;
    end else if (!ch.channel_enable || !ch.run) begin
      armed_ff <= 1'b0;
    end else if (ch.sync_hold) begin
      armed_ff <= 1'b1;
    end
  end

  wire path_level = div_mode ? (div_ff && armed_ff) : ch.in_level;
  wire drive      = ch.run && ch.out_allow && ch.channel_enable;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= drive && path_level;
    end
  end

  // Delay stages only count in delayed modes
  clkdd_latency u_lat (
    .path_select    (ch.path_select),
    .delay_code     (ch.delay_code),
    .added_delay_ps (ch.added_delay_ps)
  );

  assign ch.out_level = out_ff;
  assign ch.armed     = armed_ff;

endmodule
`default_nettype wire

// ### clkdd_top.sv
// Behaviour
// - Eight channel registers, each drives own output
// - Channel zero bit 31 restores all defaults
// - Reset write ignores other fields; rewrite after
// - Bits 18:17 pick bypass/divided/delayed/both
// - Modes add 100, 400, 500 ps latency
// - Divider acts only in divided modes
// - Bits 15:8 divide by twice code
// - Delay acts only in delayed modes
// - Bits 7:4 add code times 150 ps
// - Power-on defaults for channel and global
// - Global bit 28 selects clock input
// - Global bit 27 enable, 26 power-down
// - Global enable or pin low disables outputs
// - Power-down overrides everything
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module clkdd_top
  import clkdd_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              FIRST_CLOCK_INPUT,
  input  wire logic              SECOND_CLOCK_INPUT,
  input  wire logic              SYNC_N,
  input  wire logic              GLOBAL_ENABLE_PIN,
  output logic      [NUM_CH-1:0] CHANNEL_CLOCK_OUTPUT
);

  // Register state
  clkdd_path_t   path_ff   [NUM_CH];
  logic          chen_ff   [NUM_CH];
  logic [7:0]    div_ff    [NUM_CH];
  logic [3:0]    dly_ff    [NUM_CH];
  logic          insel_ff;
  logic          gen_ff;
  logic          pd_ff;

  clkdd_bus_st_t state_ff;
  clkdd_bus_st_t nxt_state;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic          err_ff;
  logic          in_prev_ff;

  // Bus slave: one wait state, answer in ST_ACK
  wire access    = PSEL && PENABLE;
  wire in_ack    = (state_ff == ST_ACK);
  wire commit    = access && in_ack;
  wire wr_commit = commit && PWRITE;

  wire [2:0] idx       = PADDR[IDX_HI:IDX_LO];
  wire       aligned   = (PADDR[IDX_LO-1:0] == 2'h0);
  wire       hit_ch    = aligned && (PADDR >= OFF_CH_BASE) && (PADDR <= OFF_CH_LAST);
  wire       hit_glob  = (PADDR == OFF_GLOBAL);
  wire       hit_stat  = (PADDR == OFF_STATUS);
  wire       hit_lat   = aligned && (PADDR >= OFF_LAT_BASE) && (PADDR <= OFF_LAT_LAST);
  wire       hit_ro    = hit_stat || hit_lat;
  wire       hit_rw    = hit_ch || hit_glob;
  wire       bad_read  = !(hit_rw || hit_ro);
  wire       bad_write = !hit_rw;
  wire       bad_now   = PWRITE ? bad_write : bad_read;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (access) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Read data and error captured on entry to ST_ACK
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_ff <= '0;
      err_ff   <= 1'b0;
    end else if (access && !in_ack) begin
      rdata_ff <= PWRITE ? '0 : nxt_rdata;
      err_ff   <= bad_now;
    end
  end

  assign PREADY  = in_ack && access;
  assign PSLVERR = in_ack && access && err_ff;
  assign PRDATA  = rdata_ff;

  // Write decode
  wire soft_reset = wr_commit && hit_ch && (idx == 3'h0)
                    && PWDATA[BIT_SOFT_RESET];
  wire wr_ch      = wr_commit && hit_ch && !soft_reset;
  wire wr_glob    = wr_commit && hit_glob;

  wire clkdd_path_t wr_path  = clkdd_path_t'(PWDATA[BIT_PATH_HI:BIT_PATH_LO]);
  wire              wr_chen  = PWDATA[BIT_CH_EN];
  wire [7:0]        wr_div   = PWDATA[BIT_DIV_HI:BIT_DIV_LO];
  wire [3:0]        wr_dly   = PWDATA[BIT_DLY_HI:BIT_DLY_LO];

  // Channel registers, one per output
  for (genvar n = 0; n < NUM_CH; n++) begin : g_reg
    wire sel_n = wr_ch && (idx == 3'(n));
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        path_ff[n] <= PATH_RST;
        chen_ff[n] <= CH_EN_RST;
        div_ff[n]  <= DIV_RST;
        dly_ff[n]  <= DLY_RST;
      end else if (soft_reset) begin
        path_ff[n] <= PATH_RST;
        chen_ff[n] <= CH_EN_RST;
        div_ff[n]  <= DIV_RST;
        dly_ff[n]  <= DLY_RST;
      end else if (sel_n) begin
        path_ff[n] <= wr_path;
        chen_ff[n] <= wr_chen;
        div_ff[n]  <= wr_div;
        dly_ff[n]  <= wr_dly;
      end
    end
  end

  // Global input, enable and power control
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      insel_ff <= INSEL_RST;
      gen_ff   <= GEN_RST;
      pd_ff    <= PD_RST;
    end else if (soft_reset) begin
      insel_ff <= INSEL_RST;
      gen_ff   <= GEN_RST;
      pd_ff    <= PD_RST;
    end else if (wr_glob) begin
      insel_ff <= PWDATA[BIT_INPUT_SEL];
      gen_ff   <= PWDATA[BIT_GLOBAL_EN];
      pd_ff    <= PWDATA[BIT_POWER_DOWN];
    end
  end

  // Input selection and edge detection
  wire in_level  = insel_ff ? FIRST_CLOCK_INPUT : SECOND_CLOCK_INPUT;
  wire run       = !pd_ff;
  wire out_allow = gen_ff && GLOBAL_ENABLE_PIN;
  wire sync_hold = !SYNC_N;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      in_prev_ff <= 1'b0;
    end else begin
      in_prev_ff <= run ? in_level : 1'b0;
    end
  end

  wire in_rise = run && in_level && !in_prev_ff;

  // Channel instances
  logic [NUM_CH-1:0] out_vec;
  logic [NUM_CH-1:0] arm_vec;
  logic [LAT_W-1:0]  lat_arr [NUM_CH];

  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    clkdd_chan_if cif ();

    assign cif.path_select    = path_ff[n];
    assign cif.divide_code    = div_ff[n];
    assign cif.delay_code     = dly_ff[n];
    assign cif.channel_enable = chen_ff[n];
    assign cif.run            = run;
    assign cif.out_allow      = out_allow;
    assign cif.sync_hold      = sync_hold;
    assign cif.in_level       = in_level && run;
    assign cif.in_rise        = in_rise;
    assign out_vec[n]         = cif.out_level;
    assign arm_vec[n]         = cif.armed;
    assign lat_arr[n]         = cif.added_delay_ps;

    clkdd_channel u_ch (
      .clk  (CLK),
      .nrst (NRST),
      .ch   (cif.chan)
    );
  end

  assign CHANNEL_CLOCK_OUTPUT = out_vec;

  // Read mux
  logic [DATA_W-1:0] ch_word;
  logic [DATA_W-1:0] glob_word;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] lat_word;

  always_comb begin
    ch_word = '0;
    ch_word[BIT_PATH_HI:BIT_PATH_LO] = path_ff[idx];
    ch_word[BIT_CH_EN]               = chen_ff[idx];
    ch_word[BIT_DIV_HI:BIT_DIV_LO]   = div_ff[idx];
    ch_word[BIT_DLY_HI:BIT_DLY_LO]   = dly_ff[idx];
  end

  always_comb begin
    glob_word = '0;
    glob_word[BIT_INPUT_SEL]  = insel_ff;
    glob_word[BIT_GLOBAL_EN]  = gen_ff;
    glob_word[BIT_POWER_DOWN] = pd_ff;
  end

  always_comb begin
    stat_word = '0;
    stat_word[NUM_CH-1:0]                      = out_vec;
    stat_word[BIT_ST_ARM_LO+NUM_CH-1:BIT_ST_ARM_LO] = arm_vec;
    stat_word[BIT_ST_SYNC]                     = sync_hold;
    stat_word[BIT_ST_ALLOW]                    = out_allow;
    stat_word[BIT_ST_PD]                       = pd_ff;
  end

  always_comb begin
    lat_word = '0;
    lat_word[LAT_W-1:0] = lat_arr[idx];
  end

  always_comb begin
    nxt_rdata = '0;
    if (hit_ch) begin
      nxt_rdata = ch_word;
    end else if (hit_glob) begin
      nxt_rdata = glob_word;
    end else if (hit_stat) begin
      nxt_rdata = stat_word;
    end else if (hit_lat) begin
      nxt_rdata = lat_word;
    end
  end

endmodule
`default_nettype wire

// ### clkdd_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module clkdd_asserts
  import clkdd_pkg::*;
(
  input wire logic              CLK,
  input wire logic              NRST,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              GLOBAL_ENABLE_PIN,
  input wire logic [NUM_CH-1:0] CHANNEL_CLOCK_OUTPUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  property p_rdy_req;
    PREADY |-> PSEL && PENABLE;
  endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("ready without request");
  property p_one_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_rdy_once;
    PREADY |=> !PREADY;
  endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("ready held");
  property p_err_rdy;
    PSLVERR |-> PREADY;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_ro_err;
    PREADY && PWRITE && PADDR == OFF_STATUS |-> PSLVERR;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("status write accepted");
  property p_ch_ok;
    PREADY && PADDR <= OFF_CH_LAST && PADDR[1:0] == 2'h0 |-> !PSLVERR;
  endproperty
  a_ch_ok: assert property (p_ch_ok) else $error("channel access refused");
  property p_pin_off;
    !GLOBAL_ENABLE_PIN |=> CHANNEL_CLOCK_OUTPUT == '0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("output with pin low");
  property p_rst_quiet;
    $rose(NRST) |-> (CHANNEL_CLOCK_OUTPUT == '0) [*3];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
endmodule
bind clkdd_top clkdd_asserts u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .GLOBAL_ENABLE_PIN(GLOBAL_ENABLE_PIN), .CHANNEL_CLOCK_OUTPUT(CHANNEL_CLOCK_OUTPUT));
`default_nettype wire

// ### clkdd_host.sv
`timescale 1ns/100ps
`default_nettype none
module clkdd_host
  import clkdd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              pready,
  input  wire logic              pslverr,
  input  wire logic [DATA_W-1:0] prdata,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [DATA_W-1:0] pwdata,
  output logic                   sync_n,
  output logic                   hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sync_n = 1'b1;
    hung = 1'b0;
  end
  // Request held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    hung <= (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Align dividers after programming
  task automatic sync();
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (2) @(posedge clk);
    sync_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### clkdd_bench.sv
`timescale 1ns/100ps
`default_nettype none
module clkdd_bench;
  import clkdd_pkg::*;
  logic              clk, nrst, in_a, in_b, pin_en, sync_n, hung;
  logic              psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [NUM_CH-1:0] outs;
  int                errors, n_tests, cyc;

  clkdd_top dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FIRST_CLOCK_INPUT(in_a), .SECOND_CLOCK_INPUT(in_b), .SYNC_N(sync_n),
    .GLOBAL_ENABLE_PIN(pin_en), .CHANNEL_CLOCK_OUTPUT(outs));
  clkdd_host host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sync_n(sync_n),
    .hung(hung));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // First input period 8 cycles, second 12
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) in_a <= ~in_a;
    if (cyc % 6 == 5) in_b <= ~in_b;
  end

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  function automatic logic [31:0] cfg(logic [1:0] p, logic en, logic [7:0] dv, logic [3:0] dl);
    return {13'h0000, p, en, dv, dl, 4'h0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
    chk({e, 32'h0000_0000}, {ee, 32'h0000_0000});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk({e, q}, {1'b0, x});
  endtask
  // Output rising edges of one channel over a window
  task automatic rises(input int ch, input int cycles, input int lo, input int hi);
    logic p;
    int   r;
    r = 0;
    p = outs[ch];
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (outs[ch] === 1'b1 && p !== 1'b1) r++;
      p = outs[ch];
    end
    chk_rng(r, lo, hi);
  endtask

  task automatic t_defaults();
    for (int n = 0; n < NUM_CH; n++) rd(8'(4 * n), cfg(2'h0, 1'b0, 8'h01, 4'h0));
    rd(OFF_GLOBAL, 32'h0800_0000);
  endtask
  task automatic t_fields();
    logic [1:0] p;
    logic [3:0] d;
    int         lat;
    for (int n = 0; n < NUM_CH; n++) begin
      p = 2'(n % 4);
      d = 4'(15 - n);
      wr(8'(4 * n), cfg(p, 1'b0, 8'(n + 1), d), 1'b0);
      rd(8'(4 * n), cfg(p, 1'b0, 8'(n + 1), d));
      lat = (p == 2'h0) ? 0 : (p == 2'h1) ? 100 : ((p == 2'h2) ? 400 : 500) + 150 * int'(d);
      rd(OFF_LAT_BASE + 8'(4 * n), 32'(lat));
    end
    wr(OFF_STATUS, 32'h0000_0000, 1'b1);
    wr(8'h80, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_reset_bit();
    wr(OFF_GLOBAL, 32'h1400_0000, 1'b0);
    wr(OFF_CH_BASE, 32'h8007_FFF0, 1'b0);
    t_defaults();
    wr(OFF_CH_BASE, cfg(2'h2, 1'b0, 8'h07, 4'h9), 1'b0);
    rd(OFF_CH_BASE, cfg(2'h2, 1'b0, 8'h07, 4'h9));
  endtask
  task automatic t_bypass();
    wr(8'h04, cfg(2'h0, 1'b1, 8'h05, 4'h3), 1'b0);
    rises(1, 240, 19, 21);
    wr(8'h04, cfg(2'h2, 1'b1, 8'h05, 4'h3), 1'b0);
    rises(1, 240, 19, 21);
    wr(OFF_GLOBAL, 32'h1800_0000, 1'b0);
    rises(1, 240, 29, 31);
    wr(OFF_GLOBAL, 32'h0800_0000, 1'b0);
  endtask
  task automatic t_divide();
    wr(8'h08, cfg(2'h1, 1'b1, 8'h02, 4'h0), 1'b0);
    wr(8'h0C, cfg(2'h3, 1'b1, 8'h01, 4'h7), 1'b0);
    rises(2, 60, 0, 0);
    host.sync();
    rises(2, 240, 4, 6);
    rises(3, 240, 9, 11);
  endtask
  task automatic t_gates();
    @(posedge clk);
    pin_en <= 1'b0;
    rises(1, 120, 0, 0);
    @(posedge clk);
    pin_en <= 1'b1;
    wr(OFF_GLOBAL, 32'h0000_0000, 1'b0);
    rises(1, 120, 0, 0);
    wr(OFF_GLOBAL, 32'h0C00_0000, 1'b0);
    rd(OFF_STATUS, 32'h0006_0000);
    rises(1, 120, 0, 0);
    wr(OFF_GLOBAL, 32'h0800_0000, 1'b0);
    rises(1, 240, 19, 21);
    rises(2, 120, 0, 0);
    host.sync();
    rises(2, 240, 4, 6);
  endtask

  initial begin
    wait (hung === 1'b1);
    errors++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    pin_en = 1'b1;
    in_a = 1'b0;
    in_b = 1'b0;
    cyc = 0;
    errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_defaults();
    t_fields();
    t_reset_bit();
    t_bypass();
    t_divide();
    t_gates();
    stop_test();
  end
endmodule
`default_nettype wire
